// ===== icvwh_pkg.sv
/*
  icvwh_pkg: constants for the indirect configuration-variable write helper.
  Assumes a single 100 MHz clock domain; no other packages needed.
*/
package icvwh_pkg;
  // helper register numbers in the configuration-variable space
  localparam logic [9:0] ICVWH_REG_TGT_HUND = 10'h060;
  localparam logic [9:0] ICVWH_REG_TGT_UT   = 10'h061;
  localparam logic [9:0] ICVWH_REG_VAL_HUND = 10'h062;
  localparam logic [9:0] ICVWH_REG_VAL_CMT  = 10'h063;
  // helper reset and cleared value
  localparam logic [7:0] ICVWH_CLEAR        = 8'h00;
  // field limits
  localparam logic [7:0] ICVWH_MAX_DIGIT    = 8'h09;
  localparam logic [7:0] ICVWH_MAX_UT       = 8'h63;
  localparam int         ICVWH_RADIX        = 100;
  // commit sequencing states
  typedef enum logic [0:0] {
    ICVWH_IDLE   = 1'b0,
    ICVWH_COMMIT = 1'b1
  } icvwh_state_t;
endpackage : icvwh_pkg

// ===== icvwh_station.sv
/*
  icvwh_station: command-station model that issues helper writes.
  Assumes the helper block samples wr_en on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module icvwh_station
  import icvwh_pkg::*;
(
  input  wire logic       clk,
  output logic            wr_en,
  output logic      [9:0] wr_num,
  output logic      [7:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    wr_num = 10'h000;
    wr_data = 8'h00;
  end
  // one-cycle strobe; released lines show the inverse so stale data never matches
  task automatic put(input logic [9:0] n, input logic [7:0] d);
    wr_en <= 1'b1;
    wr_num <= n;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_num <= ~n;
    wr_data <= ~d;
    @(posedge clk);
  endtask
  // address helpers first, value last since that write commits
  task automatic seq(input logic [7:0] h, u, vh, v, input bit four);
    put(ICVWH_REG_TGT_HUND, h);
    put(ICVWH_REG_TGT_UT, u);
    if (four) begin
      put(ICVWH_REG_VAL_HUND, vh);
    end
    put(ICVWH_REG_VAL_CMT, v);
  endtask
endmodule // icvwh_station
`default_nettype wire

// ===== icvwh_top.sv
/*
  icvwh_top: helper registers that compose a target configuration-variable
  number and value from digit groups, and commit it on the value write.
  Assumes decoded configuration-variable writes/reads arrive as synchronous
  strobes on clk, and that the store accepts a one-cycle write pulse.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - the target hundreds helper holds a digit from 0 to 9.
// - the target units/tens helper holds a number from 0 to 99.
// - with no value hundreds written, the value helper carries the full 8-bit value 0 to 255.
// - a write to the value helper triggers the transfer to the selected target variable.
// - after the transfer all helper registers return to zero by themselves.
// - the value hundreds helper holds a digit from 0 to 9.
// - in the four-register form the value helper carries units and tens 0 to 99, written last.
module icvwh_top
  import icvwh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [9:0] wr_num,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [9:0] rd_num,
  output logic      [7:0] rd_data,
  output logic            rd_hit,
  output logic            cv_wr,
  output logic      [9:0] cv_num,
  output logic      [7:0] cv_data
);

  icvwh_state_t state_ff;
  icvwh_state_t nxt_state;
  logic [7:0]   tgt_hund_ff;
  logic [7:0]   nxt_tgt_hund;
  logic [7:0]   tgt_ut_ff;
  logic [7:0]   nxt_tgt_ut;
  logic [7:0]   val_hund_ff;
  logic [7:0]   nxt_val_hund;
  logic [7:0]   val_cmt_ff;
  logic [7:0]   nxt_val_cmt;
  logic         cv_wr_ff;
  logic         nxt_cv_wr;
  logic [9:0]   cv_num_ff;
  logic [9:0]   nxt_cv_num;
  logic [7:0]   cv_data_ff;
  logic [7:0]   nxt_cv_data;
  logic [7:0]   rd_data_ff;
  logic [7:0]   nxt_rd_data;
  logic         rd_hit_ff;
  logic         nxt_rd_hit;
  logic [9:0]   comp_num;
  logic [9:0]   comp_val;

  // true when the given number addresses one of the four helpers
  function automatic logic is_helper(input logic [9:0] num);
    is_helper = (num >= ICVWH_REG_TGT_HUND) && (num <= ICVWH_REG_VAL_CMT);
  endfunction

  // composition of number and value from the digit groups
  always_comb begin
    comp_num = 10'(tgt_hund_ff * ICVWH_RADIX) + {2'h0, tgt_ut_ff};
    comp_val = 10'(val_hund_ff * ICVWH_RADIX) + {2'h0, val_cmt_ff};
  end

  // helper writes and the commit sequence
  always_comb begin
    nxt_state    = state_ff;
    nxt_tgt_hund = tgt_hund_ff;
    nxt_tgt_ut   = tgt_ut_ff;
    nxt_val_hund = val_hund_ff;
    nxt_val_cmt  = val_cmt_ff;
    nxt_cv_wr    = 1'b0;
    nxt_cv_num   = cv_num_ff;
    nxt_cv_data  = cv_data_ff;
    unique case (state_ff)
      ICVWH_IDLE: begin
        // out-of-range digits are ignored so a bad entry cannot aim past the store
        if (wr_en) begin
          unique case (wr_num)
            ICVWH_REG_TGT_HUND: begin
              if (wr_data <= ICVWH_MAX_DIGIT) nxt_tgt_hund = wr_data;
            end
            ICVWH_REG_TGT_UT: begin
              if (wr_data <= ICVWH_MAX_UT) nxt_tgt_ut = wr_data;
            end
            ICVWH_REG_VAL_HUND: begin
              if (wr_data <= ICVWH_MAX_DIGIT) nxt_val_hund = wr_data;
            end
            ICVWH_REG_VAL_CMT: begin
              // with hundreds at zero any byte passes; otherwise only 0..99
              if ((val_hund_ff == ICVWH_CLEAR) || (wr_data <= ICVWH_MAX_UT)) begin
                nxt_val_cmt = wr_data;
                nxt_state   = ICVWH_COMMIT;
              end
            end
            default: ;
          endcase
        end
      end
      ICVWH_COMMIT: begin
        // relies on the station having loaded the other helpers first
        nxt_cv_wr    = 1'b1;
        nxt_cv_num   = comp_num;
        nxt_cv_data  = comp_val[7:0]; // sums above 255 wrap to the low eight bits; the bench drives such sums
        nxt_tgt_hund = ICVWH_CLEAR;
        nxt_tgt_ut   = ICVWH_CLEAR;
        nxt_val_hund = ICVWH_CLEAR;
        nxt_val_cmt  = ICVWH_CLEAR;
        nxt_state    = ICVWH_IDLE;
      end
    endcase
  end

  // read-back of helpers
  always_comb begin
    nxt_rd_hit  = rd_en && is_helper(rd_num);
    nxt_rd_data = ICVWH_CLEAR;
    if (rd_en) begin
      unique case (rd_num)
        ICVWH_REG_TGT_HUND: nxt_rd_data = tgt_hund_ff;
        ICVWH_REG_TGT_UT:   nxt_rd_data = tgt_ut_ff;
        ICVWH_REG_VAL_HUND: nxt_rd_data = val_hund_ff;
        ICVWH_REG_VAL_CMT:  nxt_rd_data = val_cmt_ff;
        default:            nxt_rd_data = ICVWH_CLEAR;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff    <= ICVWH_IDLE;
      tgt_hund_ff <= ICVWH_CLEAR;
      tgt_ut_ff   <= ICVWH_CLEAR;
      val_hund_ff <= ICVWH_CLEAR;
      val_cmt_ff  <= ICVWH_CLEAR;
      cv_wr_ff    <= 1'b0;
      cv_num_ff   <= 10'h000;
      cv_data_ff  <= ICVWH_CLEAR;
      rd_data_ff  <= ICVWH_CLEAR;
      rd_hit_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      tgt_hund_ff <= nxt_tgt_hund;
      tgt_ut_ff   <= nxt_tgt_ut;
      val_hund_ff <= nxt_val_hund;
      val_cmt_ff  <= nxt_val_cmt;
      cv_wr_ff    <= nxt_cv_wr;
      cv_num_ff   <= nxt_cv_num;
      cv_data_ff  <= nxt_cv_data;
      rd_data_ff  <= nxt_rd_data;
      rd_hit_ff   <= nxt_rd_hit;
    end
  end

  assign cv_wr   = cv_wr_ff;
  assign cv_num  = cv_num_ff;
  assign cv_data = cv_data_ff;
  assign rd_data = rd_data_ff;
  assign rd_hit  = rd_hit_ff;

  // helper digits never leave their ranges
  a_tgt_hund_range: assert property (@(posedge clk) disable iff (rst)
    tgt_hund_ff <= ICVWH_MAX_DIGIT) else $error("target hundreds out of range");
  a_tgt_ut_range: assert property (@(posedge clk) disable iff (rst)
    tgt_ut_ff <= ICVWH_MAX_UT) else $error("target units/tens out of range");
  a_val_hund_range: assert property (@(posedge clk) disable iff (rst)
    val_hund_ff <= ICVWH_MAX_DIGIT) else $error("value hundreds out of range");

  // refused digits leave the held helper as it was
  a_tgt_hund_keep: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_IDLE && wr_en && wr_num == ICVWH_REG_TGT_HUND
     && wr_data > ICVWH_MAX_DIGIT) |=> $stable(tgt_hund_ff))
    else $error("oversized target hundreds was taken");
  a_tgt_ut_keep: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_IDLE && wr_en && wr_num == ICVWH_REG_TGT_UT
     && wr_data > ICVWH_MAX_UT) |=> $stable(tgt_ut_ff))
    else $error("oversized target units/tens was taken");

  // commit timing: the pulse follows the taking edge by two
  a_full_byte_commit: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_IDLE && wr_en && wr_num == ICVWH_REG_VAL_CMT
     && val_hund_ff == ICVWH_CLEAR) |-> ##2 (cv_wr && cv_data == $past(wr_data, 2)))
    else $error("full byte not committed");
  a_commit_pulse: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_IDLE && wr_en && wr_num == ICVWH_REG_VAL_CMT
     && wr_data <= ICVWH_MAX_UT) |-> ##2 cv_wr ##1 !cv_wr)
    else $error("value write did not commit once");
  // a split value above 99 is dropped whole: no commit, nothing stored
  a_refused_value: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_IDLE && wr_en && wr_num == ICVWH_REG_VAL_CMT
     && val_hund_ff != ICVWH_CLEAR && wr_data > ICVWH_MAX_UT)
    |=> (state_ff == ICVWH_IDLE && $stable(val_cmt_ff)))
    else $error("oversized split value was accepted");
  a_commit_once: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_COMMIT) |=> (state_ff == ICVWH_IDLE && cv_wr))
    else $error("commit state did not end in one pulse");
  a_commit_origin: assert property (@(posedge clk) disable iff (rst)
    cv_wr |-> ($past(state_ff) == ICVWH_COMMIT))
    else $error("commit pulse without a value write");
  a_helpers_cleared: assert property (@(posedge clk) disable iff (rst)
    cv_wr |-> (tgt_hund_ff == ICVWH_CLEAR && tgt_ut_ff == ICVWH_CLEAR
               && val_hund_ff == ICVWH_CLEAR && val_cmt_ff == ICVWH_CLEAR))
    else $error("helpers not cleared after commit");

  // composed outputs follow the digit groups held in the commit state
  a_split_value: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_COMMIT) |=> (cv_data == 8'($past(val_hund_ff) * ICVWH_RADIX
                                    + $past(val_cmt_ff))))
    else $error("split value composed wrong");
  a_target_number: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ICVWH_COMMIT) |=> (cv_num == 10'($past(tgt_hund_ff) * ICVWH_RADIX
                                   + $past(tgt_ut_ff))))
    else $error("target number composed wrong");

endmodule // icvwh_top

`default_nettype wire

// ===== icvwh_top_test.sv
/*
  icvwh_top_test: self-checking bench for the helper registers.
  Assumes icvwh_station drives the write side and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module icvwh_top_test;
  import icvwh_pkg::*;
  logic       clk, rst, wr_en, rd_en, rd_hit, cv_wr;
  logic [9:0] wr_num, rd_num, cv_num;
  logic [7:0] wr_data, rd_data, cv_data;
  int         bad_count, tests_run, h, u, vh, v, four;
  icvwh_top icvwh_top_i (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_num(wr_num),
    .wr_data(wr_data), .rd_en(rd_en), .rd_num(rd_num), .rd_data(rd_data),
    .rd_hit(rd_hit), .cv_wr(cv_wr), .cv_num(cv_num), .cv_data(cv_data));
  icvwh_station icvwh_station_i (.clk(clk), .wr_en(wr_en), .wr_num(wr_num),
    .wr_data(wr_data));
  always #5 clk = ~clk;
  // case inequality so an unknown never passes
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // composed value keeps only eight bits
  function automatic logic [7:0] val_of(input int vh, input int v);
    return 8'((vh * 100 + v) % 256);
  endfunction
  task automatic rd(input logic [9:0] n, input logic hit, input logic [7:0] d);
    rd_en <= 1'b1;
    rd_num <= n;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({9'h000, rd_hit}, {9'h000, hit});
    chk({2'h0, rd_data}, {2'h0, d});
    @(posedge clk);
  endtask
  // seq returns on the edge that raises the commit pulse; look just after it
  task automatic run(input int h, input int u, input int vh, input int v, input bit four);
    int n;
    n = 0;
    icvwh_station_i.seq(8'(h), 8'(u), 8'(vh), 8'(v), four);
    #1;
    while (cv_wr !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(10'(n), 10'd0);
    chk(cv_num, 10'(h * 100 + u));
    chk({2'h0, cv_data}, {2'h0, val_of(vh, v)});
    @(posedge clk);
    #1;
    chk({9'h000, cv_wr}, 10'h000);
    @(posedge clk);
    for (int a = 0; a < 4; a++) rd(ICVWH_REG_TGT_HUND + 10'(a), 1'b1, ICVWH_CLEAR);
    $display("commit test %0d %0d done", h * 100 + u, val_of(vh, v));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog, generous against roughly 440 cycles of tests
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    complete_run;
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rd_en = 1'b0;
    rd_num = 10'h000;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'hDC98));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // out-of-range digits are dropped, boundary digits kept
    icvwh_station_i.put(ICVWH_REG_TGT_HUND, 8'h0A);
    rd(ICVWH_REG_TGT_HUND, 1'b1, 8'h00);
    icvwh_station_i.put(ICVWH_REG_TGT_UT, 8'h64);
    rd(ICVWH_REG_TGT_UT, 1'b1, 8'h00);
    icvwh_station_i.put(ICVWH_REG_VAL_HUND, 8'h09);
    rd(ICVWH_REG_VAL_HUND, 1'b1, 8'h09);
    rd(10'h001, 1'b0, 8'h00);
    // a split value above 99 is refused while value hundreds is held
    icvwh_station_i.put(ICVWH_REG_VAL_CMT, 8'h64);
    rd(ICVWH_REG_VAL_HUND, 1'b1, 8'h09);
    $display("helper range test done");
    // four-register form first, so the stale value hundreds is overwritten
    run(3, 17, 1, 20, 1);
    run(3, 17, 0, 120, 0);
    run(9, 99, 9, 99, 1);
    run(0, 0, 0, 255, 0);
    repeat (20) begin
      four = $urandom % 2;
      h = $urandom % 10;
      u = $urandom % 100;
      vh = four ? $urandom % 10 : 0;
      v = four ? $urandom % 100 : $urandom % 256;
      run(h, u, vh, v, four[0]);
    end
    complete_run;
  end
endmodule // icvwh_top_test
`default_nettype wire
